// ### pia_acceptance.sv
// Acceptance stage and priority encoder of the program interrupt unit
`timescale 1ns/1ns
module pia_acceptance (
  input  wire logic                          clock,
  input  wire logic                          reset,
  input  wire logic [pia_pkg::NUM_CHAN-1:0]  request_n,
  input  wire logic [pia_pkg::NUM_GROUP-1:0] mask,
  input  wire logic                          inhibit_interrupts_instr,
  input  wire logic                          permit_interrupts_instr,
  input  wire logic                          program_load,
  input  wire logic                          respond_hold,
  input  wire logic                          service_done,
  input  wire logic                          first_sequence_count,
  output logic                               no_request_present,
  output logic                               accept_transfer_gate,
  output logic                               auto_program_interrupt,
  output logic [pia_pkg::ADDR_W-1:0]         response_address,
  output logic [pia_pkg::NUM_AREA-1:0]       lower_half_any_set,
  output logic [pia_pkg::NUM_AREA-1:0]       upper_half_any_set,
  output logic                               permit_state
);
  import pia_pkg::*;

  // Request synchronisers, three stages per input
  logic [NUM_CHAN-1:0]  sync1;
  logic [NUM_CHAN-1:0]  sync2;
  logic [NUM_CHAN-1:0]  sync3;
  logic [NUM_CHAN-1:0]  req_level;
  logic [NUM_CHAN-1:0]  fall;
  // Edge latches and priority flops
  logic [NUM_CHAN-1:0]  edge_latch_flops;
  logic [NUM_CHAN-1:0]  next_edge_latch;
  logic [NUM_CHAN-1:0]  priority_flops;
  logic [NUM_CHAN-1:0]  next_priority;
  logic [NUM_CHAN-1:0]  chan_enable;
  logic [NUM_CHAN-1:0]  chan_win;
  logic [NUM_CHAN-1:0]  serviced;
  // Group level encoder signals
  logic [NUM_GROUP-1:0] group_any_set;
  logic [NUM_GROUP-1:0] group_addr_bit0_gate;
  logic [NUM_GROUP-1:0] group_addr_bit1_gate;
  logic [NUM_GROUP:0]   group_blocked;
  logic [NUM_GROUP-1:0] group_win;
  logic [GROUP_W-1:0]   grp_sel;
  logic [1:0]           pos_sel;
  // Run-time state
  logic                 permit;
  logic                 instr_wait;
  logic                 no_request_present_drv;

  // Three-stage sampling of the asynchronous request pins
  always_ff @(posedge clock) begin
    if (reset) begin
      sync1 <= REQ_IDLE;
      sync2 <= REQ_IDLE;
      sync3 <= REQ_IDLE;
    end else begin
      sync1 <= request_n;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A level counts only once stages two and three agree
  always_ff @(posedge clock) begin
    if (reset) begin
      req_level <= REQ_IDLE;
    end else begin
      req_level <= (sync2 & sync3) | (req_level & (sync2 ^ sync3));
    end
  end

  // High to low transition of the filtered level
  assign fall = req_level & ~sync2 & ~sync3;

  // Permit flop: inhibit wins if both arrive together
  always_ff @(posedge clock) begin
    if (reset) begin
      permit <= PERMIT_INIT;
    end else if (inhibit_interrupts_instr) begin
      permit <= 1'b0;
    end else if (permit_interrupts_instr) begin
      permit <= 1'b1;
    end
  end

  // Per-channel enable from mask group and inhibit state
  genvar ci;
  generate
    for (ci = 0; ci < NUM_CHAN; ci++) begin : g_enable
      assign chan_enable[ci] = ~mask[ci / GROUP_SIZE]
                             & ((ci < INHIB_BASE) | permit);
    end
  endgenerate

  // Gate is open only while nothing is accepted and no load runs
  assign no_request_present_drv = ~|priority_flops;
  assign accept_transfer_gate   = no_request_present_drv & ~program_load;
  assign serviced               = chan_win & {NUM_CHAN{service_done}};

  // Latches: a new fall wins over the service clear of the same cycle
  assign next_edge_latch = (edge_latch_flops & ~serviced) | fall;

  always_ff @(posedge clock) begin
    if (reset) begin
      edge_latch_flops <= CHAN_CLEAR;
    end else begin
      edge_latch_flops <= next_edge_latch;
    end
  end

  // Priority loading; inhibitable flops are kept reset while not permitted
  assign next_priority = service_done         ? CHAN_CLEAR :
                         accept_transfer_gate ? (edge_latch_flops & chan_enable) :
                         (priority_flops & chan_enable);

  always_ff @(posedge clock) begin
    if (reset) begin
      priority_flops <= CHAN_CLEAR;
    end else begin
      priority_flops <= next_priority;
    end
  end

  // Group of four: any-set, suppression and in-group address bits
  genvar gi;
  generate
    for (gi = 0; gi < NUM_GROUP; gi++) begin : g_group
      logic [3:0] gp;
      logic [3:0] gw;
      assign gp = priority_flops[gi*GROUP_SIZE +: GROUP_SIZE];
      assign group_any_set[gi] = |gp;
      // Each set position suppresses the higher ones; the last suppresses none
      assign gw[0] = gp[0];
      assign gw[1] = gp[1] & ~gp[0];
      assign gw[2] = gp[2] & ~|gp[1:0];
      assign gw[3] = gp[3] & ~|gp[2:0];
      // Gates read the suppressed positions, so a set 3 cannot spoil a set 0 or 1
      assign group_addr_bit0_gate[gi] = gw[1] | gw[3];
      assign group_addr_bit1_gate[gi] = gw[3] | (gw[2] & ~gw[1] & ~gw[0]);
      assign chan_win[gi*GROUP_SIZE +: GROUP_SIZE] = {4{group_win[gi]}} & gw;
      // A masked group is empty one edge later, whatever the inhibit state
      a_mask_group: assert property (@(posedge clock) disable iff (reset)
        mask[gi] |=> (gp == 4'h0))
        else $error("priority flop set in masked group");
      // In-group bits name the lowest set position
      a_pos_bits: assert property (@(posedge clock) disable iff (reset)
        (|gp) |-> ({group_addr_bit1_gate[gi], group_addr_bit0_gate[gi]}
                   == (gp[0] ? 2'h0 : gp[1] ? 2'h1 : gp[2] ? 2'h2 : 2'h3)))
        else $error("in-group address bits wrong");
    end
  endgenerate

  // Areas of eight: lower half inhibits upper half
  genvar ai;
  generate
    for (ai = 0; ai < NUM_AREA; ai++) begin : g_area
      assign lower_half_any_set[ai] = group_any_set[2*ai];
      assign upper_half_any_set[ai] = group_any_set[2*ai+1]
                                    & ~group_any_set[2*ai];
      // The two halves together report exactly the area's priority flops
      a_area_halves: assert property (@(posedge clock) disable iff (reset)
        (|priority_flops[ai*AREA_SIZE +: AREA_SIZE])
          == (lower_half_any_set[ai] | upper_half_any_set[ai]))
        else $error("area any-set mismatch");
    end
  endgenerate

  // Any-set chain across groups; earlier groups inhibit later ones
  assign group_blocked[0] = 1'b0;
  genvar ki;
  generate
    for (ki = 0; ki < NUM_GROUP; ki++) begin : g_chain
      assign group_blocked[ki+1] = group_blocked[ki] | group_any_set[ki];
      assign group_win[ki]       = group_any_set[ki] & ~group_blocked[ki];
    end
  endgenerate

  // Final stage: one-hot group winner to upper address bits
  always_comb begin
    grp_sel = '0;
    pos_sel = 2'h0;
    for (int k = 0; k < NUM_GROUP; k++) begin
      if (group_win[k]) begin
        grp_sel = grp_sel | GROUP_W'(k);
        pos_sel = pos_sel | {group_addr_bit1_gate[k], group_addr_bit0_gate[k]};
      end
    end
  end

  // Combinational so the address is valid in the loading cycle
  assign response_address = RESP_BASE
                          | {1'b0, grp_sel, pos_sel};

  // After each service, wait for one program instruction to start
  always_ff @(posedge clock) begin
    if (reset) begin
      instr_wait <= WAIT_INIT;
    end else if (service_done) begin
      instr_wait <= 1'b1;
    end else if (first_sequence_count) begin
      instr_wait <= 1'b0;
    end
  end

  // Request to the sequencer; it may hold the response as long as it wants
  assign auto_program_interrupt = ~no_request_present_drv
                                & ~respond_hold
                                & ~instr_wait;
  assign no_request_present     = no_request_present_drv;
  assign permit_state           = permit;

  // Reference model of the winner, used only by the checks below
  logic [ADDR_W-1:0] ref_address;
  always_comb begin
    ref_address = RESP_BASE;
    for (int n = NUM_CHAN - 1; n >= 0; n--) begin
      if (priority_flops[n]) begin
        ref_address = RESP_BASE | ADDR_W'(n);
      end
    end
  end

  // No new priority flop may set while one is in service
  a_busy_no_load: assert property (@(posedge clock) disable iff (reset)
    (!no_request_present && !service_done) |=>
      ((priority_flops & ~$past(priority_flops)) == CHAN_CLEAR))
    else $error("priority flop set during service");

  // A program load freezes acceptance
  a_load_suspend: assert property (@(posedge clock) disable iff (reset)
    (program_load && no_request_present) |=> (priority_flops == CHAN_CLEAR))
    else $error("transfer during program load");

  // Held response never reaches the sequencer
  a_hold_response: assert property (@(posedge clock) disable iff (reset)
    respond_hold |-> !auto_program_interrupt)
    else $error("response not held");

  // All enabled latches transfer together
  a_transfer_all: assert property (@(posedge clock) disable iff (reset)
    (accept_transfer_gate && !service_done) |=>
      (priority_flops == $past(edge_latch_flops & chan_enable)))
    else $error("latched requests not all transferred");

  // A transfer that finds a request closes the gate at once
  a_start_cycle: assert property (@(posedge clock) disable iff (reset)
    (accept_transfer_gate && !service_done && |(edge_latch_flops & chan_enable)) |=>
      (!no_request_present && !accept_transfer_gate))
    else $error("gate left open after acceptance");

  // Idle gate keeps copying while nothing is set
  a_idle_copy: assert property (@(posedge clock) disable iff (reset)
    (no_request_present && !program_load) |-> accept_transfer_gate)
    else $error("idle gate closed");

  // A latch is only ever cleared by service of its own channel
  a_latch_hold: assert property (@(posedge clock) disable iff (reset)
    1'b1 |=> (($past(edge_latch_flops) & ~edge_latch_flops
               & ~$past(serviced)) == CHAN_CLEAR))
    else $error("latch cleared without service");

  // A detected fall always lands in its latch
  a_fall_sets: assert property (@(posedge clock) disable iff (reset)
    (|fall) |=> ((edge_latch_flops & $past(fall)) == $past(fall)))
    else $error("fall not latched");

  // End of cycle empties the priority flops
  a_end_clear: assert property (@(posedge clock) disable iff (reset)
    service_done |=> (priority_flops == CHAN_CLEAR))
    else $error("priority not cleared at cycle end");

  // No request until a program instruction has started
  a_one_instr: assert property (@(posedge clock) disable iff (reset)
    service_done ##1 !first_sequence_count |-> !auto_program_interrupt)
    else $error("back to back service");

  // The lowest set channel gives the address
  a_lowest_wins: assert property (@(posedge clock) disable iff (reset)
    (|priority_flops) |-> (response_address == ref_address))
    else $error("wrong winning address");

  // Exactly one winner while anything is set
  a_single_win: assert property (@(posedge clock) disable iff (reset)
    (|priority_flops) |-> $onehot(chan_win))
    else $error("winner not unique");

  // Upper half never claims while lower half is set
  a_upper_half: assert property (@(posedge clock) disable iff (reset)
    (|(upper_half_any_set & lower_half_any_set)) == 1'b0)
    else $error("upper half set with lower half");

  // Inhibited state keeps inhibitable flops reset
  a_inhibit_hold: assert property (@(posedge clock) disable iff (reset)
    (!permit && $past(!permit)) |->
      (priority_flops[NUM_CHAN-1:INHIB_BASE] == '0))
    else $error("inhibitable flop set while inhibited");

  // Exactly one group wins while anything is set
  a_group_unique: assert property (@(posedge clock) disable iff (reset)
    (|priority_flops) |-> $onehot(group_win))
    else $error("group winner not unique");

  // The winner's latch is gone after its service unless it fell again
  a_winner_clear: assert property (@(posedge clock) disable iff (reset)
    service_done |=> ((edge_latch_flops & $past(chan_win) & ~$past(fall)) == CHAN_CLEAR))
    else $error("serviced latch still set");

  // The cycle after a service the wait flag stands and no request goes out
  a_gap_wait: assert property (@(posedge clock) disable iff (reset)
    $past(service_done) |-> (instr_wait && !auto_program_interrupt))
    else $error("request before program instruction");

  // Inhibit always lands, even when permit arrives in the same cycle
  a_inhibit_wins: assert property (@(posedge clock) disable iff (reset)
    inhibit_interrupts_instr |=> !permit_state)
    else $error("inhibit lost to permit");

  // Reset leaves the block idle with acceptance permitted
  a_reset_idle: assert property (@(posedge clock)
    reset |=> (no_request_present && !auto_program_interrupt
               && (response_address == RESP_BASE) && permit_state))
    else $error("block not idle after reset");

endmodule : pia_acceptance

// ### pia_acceptance_tb.sv
// Self-checking bench for the priority interrupt acceptance stage
`timescale 1ns/1ns
module pia_acceptance_tb;
  import pia_pkg::*;
  logic                 clock = 1'b0;
  logic                 reset = 1'b1;
  logic [NUM_CHAN-1:0]  request_n = REQ_IDLE;
  logic [NUM_GROUP-1:0] mask = '0;
  logic                 inhibit_cmd = 1'b0;
  logic                 permit_cmd = 1'b0;
  logic                 program_load = 1'b0;
  logic                 respond_hold = 1'b0;
  logic [3:0]           delay = 4'h0;
  logic                 service_done, first_sequence_count, no_request_present;
  logic                 accept_transfer_gate, auto_program_interrupt, permit_state;
  logic [ADDR_W-1:0]    response_address;
  logic [NUM_AREA-1:0]  lower_half_any_set, upper_half_any_set;
  logic [NUM_CHAN-1:0]  vec;
  logic [ADDR_W-1:0]    served[$];
  int                   exp_q[$];
  int                   miscompares = 0;
  int                   total_checks = 0;
  int                   seed = 34;
  int                   ch, ch2;

  always #5 clock = ~clock;

  pia_acceptance i_pia_acceptance (.clock(clock), .reset(reset), .request_n(request_n),
    .mask(mask), .inhibit_interrupts_instr(inhibit_cmd), .permit_interrupts_instr(permit_cmd),
    .program_load(program_load), .respond_hold(respond_hold), .service_done(service_done),
    .first_sequence_count(first_sequence_count), .no_request_present(no_request_present),
    .accept_transfer_gate(accept_transfer_gate), .auto_program_interrupt(auto_program_interrupt),
    .response_address(response_address), .lower_half_any_set(lower_half_any_set),
    .upper_half_any_set(upper_half_any_set), .permit_state(permit_state));

  pia_sequencer_model i_pia_sequencer_model (.clock(clock), .reset(reset),
    .auto_program_interrupt(auto_program_interrupt), .delay(delay),
    .service_done(service_done), .first_sequence_count(first_sequence_count));

  // Record the address presented at every end of cycle
  always @(posedge clock) begin
    if (!reset && service_done === 1'b1) begin
      served.push_back(response_address);
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic stop_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // Pins held low and high for three cycles, above the two-cycle minimum
  task automatic pulse_pins(input logic [NUM_CHAN-1:0] chans);
    @(negedge clock);
    request_n = ~chans;
    repeat (3) @(negedge clock);
    request_n = REQ_IDLE;
    repeat (3) @(negedge clock);
  endtask : pulse_pins

  // Waits for the services listed in exp_q and compares them in that order
  task automatic wait_served();
    int n;
    n = 0;
    while (served.size() < exp_q.size() && n < 3000) begin
      @(negedge clock);
      n++;
    end
    repeat (30) @(negedge clock);
    check("served count", 16'(exp_q.size()), 16'(served.size()));
    foreach (served[i]) begin
      if (i < exp_q.size()) begin
        check("served addr", 16'(RESP_BASE + ADDR_W'(exp_q[i])), 16'(served[i]));
      end
    end
    served.delete();
  endtask : wait_served

  // Requests latched together are served in ascending channel number
  task automatic expect_served(input logic [NUM_CHAN-1:0] chans);
    exp_q.delete();
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (chans[i]) begin
        exp_q.push_back(i);
      end
    end
    wait_served();
  endtask : expect_served

  function automatic logic [NUM_CHAN-1:0] one_hot(input int c);
    return {{(NUM_CHAN-1){1'b0}}, 1'b1} << c;
  endfunction : one_hot

  // Expected per-area half flags while a single channel is set
  function automatic logic [15:0] half_bits(input int c, input bit upper);
    return (((c % AREA_SIZE) >= GROUP_SIZE) == upper) ? (16'h1 << (c / AREA_SIZE)) : 16'h0;
  endfunction : half_bits

  // Main sequence of scenarios
  initial begin
    repeat (16) @(negedge clock);
    reset = 1'b0;
    repeat (4) @(negedge clock);
    check("no request", 16'(1), 16'(no_request_present));
    check("idle address", 16'(RESP_BASE), 16'(response_address));
    check("permit", 16'(PERMIT_INIT), 16'(permit_state));
    for (int k = 0; k < 6; k++) begin
      ch = (k == 0) ? 0 : (k == 1) ? NUM_CHAN - 1 : $unsigned($random(seed)) % NUM_CHAN;
      delay = 4'($unsigned($random(seed)));
      pulse_pins(one_hot(ch));
      expect_served(one_hot(ch));
    end
    for (int k = 0; k < 3; k++) begin
      vec = '0;
      repeat (4) vec[$unsigned($random(seed)) % NUM_CHAN] = 1'b1;
      pulse_pins(vec);
      expect_served(vec);
    end
    // Positions 0 with 3, then 1 with 3, share a group
    vec = one_hot(8) | one_hot(11) | one_hot(13) | one_hot(15);
    pulse_pins(vec);
    expect_served(vec);
    // A higher priority fall during a slow service waits its turn
    delay = 4'hf;
    pulse_pins(one_hot(50));
    pulse_pins(one_hot(3));
    exp_q.delete();
    exp_q.push_back(50);
    exp_q.push_back(3);
    wait_served();
    delay = 4'h1;
    ch = $unsigned($random(seed)) % NUM_CHAN;
    mask[ch / 4] = 1'b1;
    pulse_pins(one_hot(ch));
    repeat (20) @(negedge clock);
    check("masked idle", 16'(1), 16'(no_request_present));
    mask = '0;
    expect_served(one_hot(ch));
    ch = INHIB_BASE + $unsigned($random(seed)) % INHIB_BASE;
    ch2 = $unsigned($random(seed)) % INHIB_BASE;
    inhibit_cmd = 1'b1;
    @(negedge clock);
    inhibit_cmd = 1'b0;
    check("inhibited", 16'(0), 16'(permit_state));
    pulse_pins(one_hot(ch) | one_hot(ch2));
    expect_served(one_hot(ch2));
    permit_cmd = 1'b1;
    @(negedge clock);
    permit_cmd = 1'b0;
    expect_served(one_hot(ch));
    program_load = 1'b1;
    @(negedge clock);
    check("load gate", 16'(0), 16'(accept_transfer_gate));
    pulse_pins(one_hot(ch2));
    repeat (10) @(negedge clock);
    check("load idle", 16'(1), 16'(no_request_present));
    program_load = 1'b0;
    expect_served(one_hot(ch2));
    respond_hold = 1'b1;
    pulse_pins(one_hot(ch));
    repeat (10) @(negedge clock);
    check("held request", 16'(0), 16'(auto_program_interrupt));
    check("held present", 16'(0), 16'(no_request_present));
    check("held address", 16'(RESP_BASE + ADDR_W'(ch)), 16'(response_address));
    check("lower half", half_bits(ch, 1'b0), 16'(lower_half_any_set));
    check("upper half", half_bits(ch, 1'b1), 16'(upper_half_any_set));
    respond_hold = 1'b0;
    expect_served(one_hot(ch));
    // Inhibit and permit in one cycle: inhibit wins
    inhibit_cmd = 1'b1;
    permit_cmd = 1'b1;
    @(negedge clock);
    inhibit_cmd = 1'b0;
    permit_cmd = 1'b0;
    check("inhibit over permit", 16'(0), 16'(permit_state));
    stop_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    miscompares++;
    stop_test();
  end
endmodule : pia_acceptance_tb

// ### pia_pkg.sv
// Constants shared by the priority interrupt acceptance stage
package pia_pkg;
  // Channel organisation: areas of eight, groups of four
  localparam int NUM_CHAN   = 128;
  localparam int NUM_GROUP  = NUM_CHAN / 4;
  localparam int NUM_AREA   = NUM_CHAN / 8;
  localparam int GROUP_SIZE = 4;
  localparam int AREA_SIZE  = 8;
  // Field widths of the response address
  localparam int CHAN_W     = 7;
  localparam int GROUP_W    = 5;
  localparam int ADDR_W     = 8;
  // First inhibitable channel, response address 300 octal
  localparam int INHIB_BASE = 64;
  // Response address of channel 0 (200 octal)
  localparam logic [ADDR_W-1:0] RESP_BASE = 8'h80;
  // Bit positions inside the response address
  localparam int ADDR_LO_POS  = 0;
  localparam int ADDR_GRP_POS = 2;
  // Reset values
  localparam logic [NUM_CHAN-1:0] REQ_IDLE    = {NUM_CHAN{1'b1}};
  localparam logic [NUM_CHAN-1:0] CHAN_CLEAR  = {NUM_CHAN{1'b0}};
  localparam logic                PERMIT_INIT = 1'b1;
  localparam logic                WAIT_INIT   = 1'b0;
endpackage : pia_pkg

// ### pia_sequencer_model.sv
// Behavioural sequencer that services each interrupt request it sees
`timescale 1ns/1ns
module pia_sequencer_model (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       auto_program_interrupt,
  input  wire logic [3:0] delay,
  output logic            service_done,
  output logic            first_sequence_count
);
  // Waits out a chosen response time, ends the cycle, then runs one instruction
  initial begin
    service_done = 1'b0;
    first_sequence_count = 1'b0;
    forever begin
      @(negedge clock);
      if (!reset && auto_program_interrupt === 1'b1) begin
        repeat (delay) @(negedge clock);
        service_done = 1'b1;
        @(negedge clock);
        service_done = 1'b0;
        repeat (2) @(negedge clock);
        first_sequence_count = 1'b1;
        @(negedge clock);
        first_sequence_count = 1'b0;
      end
    end
  end
endmodule : pia_sequencer_model
